// *** fwsp_params.svh ***
// Purpose: constants of the flash status polling controller
// Assumes: 10 MHz ref_clk, 32-bit APB register window
// Notes: definitions only
`ifndef FWSP_PARAMS_SVH
`define FWSP_PARAMS_SVH

// register byte offsets
`define FWSP_OFF_CTRL 8'h00
`define FWSP_OFF_ADDR 8'h04
`define FWSP_OFF_LIMIT 8'h08
`define FWSP_OFF_STATUS 8'h0C
`define FWSP_OFF_DATA 8'h10
`define FWSP_OFF_IRQ_STAT 8'h14
`define FWSP_OFF_IRQ_CLR 8'h18
`define FWSP_OFF_IRQ_EN 8'h1C
`define FWSP_OFF_RST_CMD 8'h20

// control fields
`define FWSP_CTRL_START 0
`define FWSP_CTRL_SECTOR 1

// status byte fields
`define FWSP_BIT_POLL 7
`define FWSP_BIT_TOGGLE 6
`define FWSP_BIT_FAIL 5
`define FWSP_BIT_ERASE_STARTED 3
`define FWSP_BIT_SECTOR_TOGGLE 2

// interrupt fields
`define FWSP_IRQ_OK 0
`define FWSP_IRQ_FAIL 1
`define FWSP_IRQ_GAVE_UP 2

// reset values
`define FWSP_RST_LIMIT 16'h0000
`define FWSP_RST_RST_CMD 8'hF0
`define FWSP_RST_IRQ_EN 3'h0

// timing
`define FWSP_CLK_PERIOD_NS 100
`define FWSP_T_RC_NS 70
`define FWSP_T_WC_NS 70
`define FWSP_RD_CYC (((`FWSP_T_RC_NS + `FWSP_CLK_PERIOD_NS - 1) / `FWSP_CLK_PERIOD_NS) < 1 ? 1 : \
    ((`FWSP_T_RC_NS + `FWSP_CLK_PERIOD_NS - 1) / `FWSP_CLK_PERIOD_NS))
`define FWSP_WR_CYC (((`FWSP_T_WC_NS + `FWSP_CLK_PERIOD_NS - 1) / `FWSP_CLK_PERIOD_NS) < 1 ? 1 : \
    ((`FWSP_T_WC_NS + `FWSP_CLK_PERIOD_NS - 1) / `FWSP_CLK_PERIOD_NS))

`endif

// *** fwsp_pkg.sv ***
// Purpose: types of the flash status polling controller
// Assumes: constants live in fwsp_params.svh
// Notes: nothing here is imported; use fwsp_pkg::name
package fwsp_pkg;
    typedef enum logic [1:0] {
        FWSP_RES_NONE,
        FWSP_RES_OK,
        FWSP_RES_FAIL,
        FWSP_RES_GAVE_UP
    } fwsp_result_e;

    typedef enum logic [1:0] {
        FWSP_B_IDLE,
        FWSP_B_ACT,
        FWSP_B_END
    } fwsp_bus_state_e;

    typedef enum logic [3:0] {
        FWSP_P_IDLE,
        FWSP_P_RD1,
        FWSP_P_RD2,
        FWSP_P_CHK,
        FWSP_P_RD3,
        FWSP_P_RD4,
        FWSP_P_CHK2,
        FWSP_P_DATA,
        FWSP_P_RST,
        FWSP_P_FIN
    } fwsp_poll_state_e;
endpackage

// *** fwsp_bus_cycle.sv ***
// Purpose: one asynchronous flash read or write cycle on ce/oe/we strobes
// Assumes: strobe low for at least the access time, then one idle cycle
// Notes: all outputs except idle are flip-flops; idle is decoded from the state flop
`timescale 1ns/1ns
`default_nettype none
`include "fwsp_params.svh"

module fwsp_bus_cycle #(
    parameter int ADDR_W = 19
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // request
    input wire logic start,
    input wire logic is_write,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    output logic idle,
    output logic done,
    output logic [7:0] rdata,
    // flash pins
    output logic [ADDR_W-1:0] fl_addr,
    output logic fl_ce_b,
    output logic fl_oe_b,
    output logic fl_we_b,
    output logic [7:0] fl_dq_o,
    output logic fl_dq_oe,
    input wire logic [7:0] fl_dq_i
);
    localparam logic [3:0] RD_CYC = 4'(`FWSP_RD_CYC);
    localparam logic [3:0] WR_CYC = 4'(`FWSP_WR_CYC);

    fwsp_pkg::fwsp_bus_state_e st_ff, nxt_st;
    logic [3:0] cnt_ff, nxt_cnt;
    logic wr_ff, nxt_wr;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [7:0] dqo_ff, nxt_dqo, rd_ff, nxt_rd;
    logic done_ff, nxt_done;

    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_wr = wr_ff;
        nxt_addr = addr_ff;
        nxt_dqo = dqo_ff;
        nxt_rd = rd_ff;
        nxt_done = 1'b0;
        case (st_ff)
            fwsp_pkg::FWSP_B_IDLE: begin
                if (start) begin
                    nxt_st = fwsp_pkg::FWSP_B_ACT;
                    nxt_wr = is_write;
                    nxt_addr = addr;
                    nxt_dqo = wdata;
                    nxt_cnt = is_write ? WR_CYC : RD_CYC;
                end
            end
            fwsp_pkg::FWSP_B_ACT: begin
                if (cnt_ff <= 4'h1) begin
                    // data is sampled while oe is still low
                    if (!wr_ff) begin
                        nxt_rd = fl_dq_i;
                    end
                    nxt_done = 1'b1;
                    nxt_st = fwsp_pkg::FWSP_B_END;
                end else begin
                    nxt_cnt = cnt_ff - 4'h1;
                end
            end
            fwsp_pkg::FWSP_B_END: begin
                // strobes high for a cycle so each read completes on its own
                nxt_st = fwsp_pkg::FWSP_B_IDLE;
            end
            default: begin
                nxt_st = fwsp_pkg::FWSP_B_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st_ff <= fwsp_pkg::FWSP_B_IDLE;
            cnt_ff <= 4'h0;
            wr_ff <= 1'b0;
            addr_ff <= '0;
            dqo_ff <= 8'h00;
            rd_ff <= 8'h00;
            done_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            wr_ff <= nxt_wr;
            addr_ff <= nxt_addr;
            dqo_ff <= nxt_dqo;
            rd_ff <= nxt_rd;
            done_ff <= nxt_done;
        end
    end

    // strobe flops follow the next state so they stay glitch free
    logic ce_ff, oe_ff, we_ff, dq_oe_ff;
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ce_ff <= 1'b1;
            oe_ff <= 1'b1;
            we_ff <= 1'b1;
            dq_oe_ff <= 1'b0;
        end else begin
            ce_ff <= !(nxt_st == fwsp_pkg::FWSP_B_ACT);
            oe_ff <= !(nxt_st == fwsp_pkg::FWSP_B_ACT && !nxt_wr);
            we_ff <= !(nxt_st == fwsp_pkg::FWSP_B_ACT && nxt_wr);
            dq_oe_ff <= (nxt_st == fwsp_pkg::FWSP_B_ACT && nxt_wr);
        end
    end

    assign idle = (st_ff == fwsp_pkg::FWSP_B_IDLE);
    assign done = done_ff;
    assign rdata = rd_ff;
    assign fl_addr = addr_ff;
    assign fl_ce_b = ce_ff;
    assign fl_oe_b = oe_ff;
    assign fl_we_b = we_ff;
    assign fl_dq_o = dqo_ff;
    assign fl_dq_oe = dq_oe_ff;
endmodule
`default_nettype wire

// *** fwsp_poll_ctrl.sv ***
// Purpose: host-side toggle bit polling of a parallel NOR flash, driven over APB
// Assumes: flash pins synchronous to ref_clk; one APB wait state per access
// Notes: software writes the poll address, then sets start; result and irq follow
// Behaviour
// - begin status check with two back-to-back full byte reads, compare toggle bit
// - toggle bit steady across two reads means done; next read gives array data
// - toggle bit still changing: also look at the time-limit failure bit
// - failure bit high: compare toggle again; steady now means success
// - still toggling after failure bit high: failed; write the reset command
// - toggling without failure: keep polling or leave; always restart at first read
`timescale 1ns/1ns
`default_nettype none
`include "fwsp_params.svh"

module fwsp_poll_ctrl #(
    parameter int ADDR_W = 19
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic irq,
    // flash pins
    output logic [ADDR_W-1:0] fl_addr,
    output logic fl_ce_b,
    output logic fl_oe_b,
    output logic fl_we_b,
    output logic [7:0] fl_dq_o,
    output logic fl_dq_oe,
    input wire logic [7:0] fl_dq_i
);
    // toggle bit differs between two status bytes
    function automatic logic toggled(input logic [7:0] a, input logic [7:0] b, input logic sector);
        toggled = sector ? (a[`FWSP_BIT_SECTOR_TOGGLE] != b[`FWSP_BIT_SECTOR_TOGGLE])
                         : (a[`FWSP_BIT_TOGGLE] != b[`FWSP_BIT_TOGGLE]);
    endfunction

    fwsp_pkg::fwsp_poll_state_e st_ff, nxt_st;
    logic [7:0] first_ff, nxt_first, last_ff, nxt_last, data_ff, nxt_data;
    logic [15:0] round_ff, nxt_round;
    logic [1:0] rd_cnt_ff, nxt_rd_cnt;
    logic wait_ff, nxt_wait;
    fwsp_pkg::fwsp_result_e res_ff, nxt_res;
    logic [2:0] ev;
    logic bc_start, bc_write, bc_idle, bc_done;
    logic [7:0] bc_rdata;

    // register file state
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [15:0] limit_ff, nxt_limit;
    logic sector_ff, nxt_sector;
    logic [7:0] rst_cmd_ff, nxt_rst_cmd;
    logic [2:0] irq_stat_ff, nxt_irq_stat, irq_en_ff, nxt_irq_en;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr, irq_ff, nxt_irq;

    logic apb_access, apb_fire, wr_fire, start_req, mapped;
    assign apb_access = psel && penable && !pready_ff;
    assign apb_fire = psel && penable && pready_ff;
    assign wr_fire = apb_fire && pwrite && !pslverr_ff;
    assign start_req = wr_fire && paddr == `FWSP_OFF_CTRL && pwdata[`FWSP_CTRL_START];

    fwsp_bus_cycle #(.ADDR_W(ADDR_W)) u_bus (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .start(bc_start),
        .is_write(bc_write),
        .addr(addr_ff),
        .wdata(rst_cmd_ff),
        .idle(bc_idle),
        .done(bc_done),
        .rdata(bc_rdata),
        .fl_addr(fl_addr),
        .fl_ce_b(fl_ce_b),
        .fl_oe_b(fl_oe_b),
        .fl_we_b(fl_we_b),
        .fl_dq_o(fl_dq_o),
        .fl_dq_oe(fl_dq_oe),
        .fl_dq_i(fl_dq_i)
    );

    logic in_cycle;
    assign in_cycle = st_ff == fwsp_pkg::FWSP_P_RD1 || st_ff == fwsp_pkg::FWSP_P_RD2 ||
                      st_ff == fwsp_pkg::FWSP_P_RD3 || st_ff == fwsp_pkg::FWSP_P_RD4 ||
                      st_ff == fwsp_pkg::FWSP_P_DATA || st_ff == fwsp_pkg::FWSP_P_RST;
    assign bc_start = in_cycle && bc_idle && !wait_ff;
    assign bc_write = st_ff == fwsp_pkg::FWSP_P_RST;

    always_comb begin
        nxt_st = st_ff;
        nxt_first = first_ff;
        nxt_last = last_ff;
        nxt_data = data_ff;
        nxt_round = round_ff;
        nxt_rd_cnt = rd_cnt_ff;
        nxt_res = res_ff;
        nxt_wait = bc_start ? 1'b1 : (bc_done ? 1'b0 : wait_ff);
        ev = 3'h0;
        case (st_ff)
            fwsp_pkg::FWSP_P_IDLE: begin
                if (start_req) begin
                    nxt_st = fwsp_pkg::FWSP_P_RD1;
                    nxt_round = 16'h0000;
                    nxt_rd_cnt = 2'h0;
                    nxt_res = fwsp_pkg::FWSP_RES_NONE;
                end
            end
            fwsp_pkg::FWSP_P_RD1, fwsp_pkg::FWSP_P_RD3: begin
                if (bc_done) begin
                    nxt_first = bc_rdata;
                    nxt_rd_cnt = rd_cnt_ff + 2'h1;
                    nxt_st = (st_ff == fwsp_pkg::FWSP_P_RD1) ? fwsp_pkg::FWSP_P_RD2 : fwsp_pkg::FWSP_P_RD4;
                end
            end
            fwsp_pkg::FWSP_P_RD2, fwsp_pkg::FWSP_P_RD4: begin
                if (bc_done) begin
                    nxt_last = bc_rdata;
                    nxt_rd_cnt = rd_cnt_ff + 2'h1;
                    nxt_st = (st_ff == fwsp_pkg::FWSP_P_RD2) ? fwsp_pkg::FWSP_P_CHK : fwsp_pkg::FWSP_P_CHK2;
                end
            end
            fwsp_pkg::FWSP_P_CHK: begin
                if (!toggled(first_ff, last_ff, sector_ff)) begin
                    nxt_st = fwsp_pkg::FWSP_P_DATA;
                end else if (last_ff[`FWSP_BIT_FAIL]) begin
                    nxt_st = fwsp_pkg::FWSP_P_RD3;
                    nxt_rd_cnt = 2'h0;
                end else if (limit_ff != 16'h0000 && round_ff + 16'h0001 >= limit_ff) begin
                    nxt_res = fwsp_pkg::FWSP_RES_GAVE_UP;
                    ev[`FWSP_IRQ_GAVE_UP] = 1'b1;
                    nxt_st = fwsp_pkg::FWSP_P_FIN;
                end else begin
                    nxt_round = round_ff + 16'h0001;
                    nxt_rd_cnt = 2'h0;
                    nxt_st = fwsp_pkg::FWSP_P_RD1;
                end
            end
            fwsp_pkg::FWSP_P_CHK2: begin
                if (!toggled(first_ff, last_ff, sector_ff)) begin
                    nxt_st = fwsp_pkg::FWSP_P_DATA;
                end else begin
                    nxt_st = fwsp_pkg::FWSP_P_RST;
                end
            end
            fwsp_pkg::FWSP_P_DATA: begin
                if (bc_done) begin
                    nxt_data = bc_rdata;
                    nxt_res = fwsp_pkg::FWSP_RES_OK;
                    ev[`FWSP_IRQ_OK] = 1'b1;
                    nxt_st = fwsp_pkg::FWSP_P_FIN;
                end
            end
            fwsp_pkg::FWSP_P_RST: begin
                if (bc_done) begin
                    nxt_res = fwsp_pkg::FWSP_RES_FAIL;
                    ev[`FWSP_IRQ_FAIL] = 1'b1;
                    nxt_st = fwsp_pkg::FWSP_P_FIN;
                end
            end
            fwsp_pkg::FWSP_P_FIN: begin
                // lets the bus cycle return to idle before a new start
                nxt_st = fwsp_pkg::FWSP_P_IDLE;
            end
            default: begin
                nxt_st = fwsp_pkg::FWSP_P_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st_ff <= fwsp_pkg::FWSP_P_IDLE;
            first_ff <= 8'h00;
            last_ff <= 8'h00;
            data_ff <= 8'h00;
            round_ff <= 16'h0000;
            rd_cnt_ff <= 2'h0;
            wait_ff <= 1'b0;
            res_ff <= fwsp_pkg::FWSP_RES_NONE;
        end else begin
            st_ff <= nxt_st;
            first_ff <= nxt_first;
            last_ff <= nxt_last;
            data_ff <= nxt_data;
            round_ff <= nxt_round;
            rd_cnt_ff <= nxt_rd_cnt;
            wait_ff <= nxt_wait;
            res_ff <= nxt_res;
        end
    end

    // register file; writes land on the edge that samples pready high
    always_comb begin
        nxt_addr = addr_ff;
        nxt_limit = limit_ff;
        nxt_sector = sector_ff;
        nxt_rst_cmd = rst_cmd_ff;
        nxt_irq_en = irq_en_ff;
        nxt_pready = apb_access;
        nxt_prdata = prdata_ff;
        nxt_pslverr = 1'b0;
        mapped = paddr[1:0] == 2'h0 && paddr <= `FWSP_OFF_RST_CMD;
        // address and options frozen while a poll runs
        if (wr_fire && st_ff == fwsp_pkg::FWSP_P_IDLE) begin
            case (paddr)
                `FWSP_OFF_CTRL: nxt_sector = pwdata[`FWSP_CTRL_SECTOR];
                `FWSP_OFF_ADDR: nxt_addr = pwdata[ADDR_W-1:0];
                `FWSP_OFF_LIMIT: nxt_limit = pwdata[15:0];
                `FWSP_OFF_RST_CMD: nxt_rst_cmd = pwdata[7:0];
                default: ;
            endcase
        end
        if (wr_fire && paddr == `FWSP_OFF_IRQ_EN) begin
            nxt_irq_en = pwdata[2:0];
        end
        // set wins over a clear in the same cycle
        nxt_irq_stat = irq_stat_ff & ~((wr_fire && paddr == `FWSP_OFF_IRQ_CLR) ? pwdata[2:0] : 3'h0);
        nxt_irq_stat = nxt_irq_stat | ev;
        nxt_irq = |(nxt_irq_stat & nxt_irq_en);
        if (apb_access) begin
            nxt_pslverr = !mapped;
            case (paddr)
                `FWSP_OFF_CTRL: nxt_prdata = {30'h0, sector_ff, 1'b0};
                `FWSP_OFF_ADDR: nxt_prdata = 32'(addr_ff);
                `FWSP_OFF_LIMIT: nxt_prdata = {16'h0, limit_ff};
                `FWSP_OFF_STATUS: nxt_prdata = {round_ff, last_ff, 5'h0, res_ff, st_ff != fwsp_pkg::FWSP_P_IDLE};
                `FWSP_OFF_DATA: nxt_prdata = {24'h0, data_ff};
                `FWSP_OFF_IRQ_STAT: nxt_prdata = {29'h0, irq_stat_ff};
                `FWSP_OFF_IRQ_EN: nxt_prdata = {29'h0, irq_en_ff};
                `FWSP_OFF_RST_CMD: nxt_prdata = {24'h0, rst_cmd_ff};
                default: nxt_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            addr_ff <= '0;
            limit_ff <= `FWSP_RST_LIMIT;
            sector_ff <= 1'b0;
            rst_cmd_ff <= `FWSP_RST_RST_CMD;
            irq_stat_ff <= 3'h0;
            irq_en_ff <= `FWSP_RST_IRQ_EN;
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            addr_ff <= nxt_addr;
            limit_ff <= nxt_limit;
            sector_ff <= nxt_sector;
            rst_cmd_ff <= nxt_rst_cmd;
            irq_stat_ff <= nxt_irq_stat;
            irq_en_ff <= nxt_irq_en;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            irq_ff <= nxt_irq;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;

    a_two_reads_first: assert property (@(posedge ref_clk) disable iff (!rst_b)
        st_ff == fwsp_pkg::FWSP_P_CHK |-> rd_cnt_ff == 2'h2 && $past(st_ff) == fwsp_pkg::FWSP_P_RD2)
        else $error("verdict taken without two consecutive reads");
    a_steady_reads_data: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (st_ff == fwsp_pkg::FWSP_P_CHK && !toggled(first_ff, last_ff, sector_ff))
        |=> st_ff == fwsp_pkg::FWSP_P_DATA ##[1:6] (!fl_oe_b && !fl_ce_b))
        else $error("steady toggle not followed by an array read");
    a_fail_bit_looked: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (st_ff == fwsp_pkg::FWSP_P_CHK && toggled(first_ff, last_ff, sector_ff) && last_ff[`FWSP_BIT_FAIL])
        |=> st_ff == fwsp_pkg::FWSP_P_RD3)
        else $error("failure bit high but no second toggle check");
    a_recheck_success: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (st_ff == fwsp_pkg::FWSP_P_CHK2 && !toggled(first_ff, last_ff, sector_ff))
        |=> st_ff == fwsp_pkg::FWSP_P_DATA ##[1:8] res_ff == fwsp_pkg::FWSP_RES_OK)
        else $error("steady recheck not reported as success");
    a_fail_reset_cmd: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (st_ff == fwsp_pkg::FWSP_P_CHK2 && toggled(first_ff, last_ff, sector_ff))
        |-> ##[2:6] (!fl_we_b && fl_dq_oe && fl_dq_o == rst_cmd_ff))
        else $error("failed operation not followed by reset command write");
    a_restart_at_top: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (st_ff == fwsp_pkg::FWSP_P_CHK && toggled(first_ff, last_ff, sector_ff) && !last_ff[`FWSP_BIT_FAIL])
        |=> (st_ff == fwsp_pkg::FWSP_P_RD1 && rd_cnt_ff == 2'h0) || res_ff == fwsp_pkg::FWSP_RES_GAVE_UP)
        else $error("polling resumed somewhere other than the first read");
endmodule
`default_nettype wire

// *** fwsp_flash_model.sv ***
// Purpose: behavioural flash that answers status reads during an embedded operation
// Assumes: pins synchronous to ref_clk, one read per strobe pulse
// Notes: busy for busy_n reads; fail_on sets the time-limit bit; stuck keeps it busy
`timescale 1ns/1ns
`default_nettype none
module fwsp_flash_model (
    // clock
    input wire logic ref_clk,
    // scenario control
    input wire logic arm,
    input wire logic [15:0] busy_n,
    input wire logic fail_on,
    input wire logic stuck,
    input wire logic erase,
    input wire logic [7:0] arr,
    output logic [7:0] wr_byte,
    output logic [18:0] rd_addr,
    // flash pins
    input wire logic [18:0] fl_addr,
    input wire logic fl_ce_b,
    input wire logic fl_oe_b,
    input wire logic fl_we_b,
    input wire logic [7:0] fl_dq_o,
    input wire logic fl_dq_oe,
    output logic [7:0] fl_dq_i
);
    int k = 0;
    logic rd_q = 1'b0;
    logic aborted = 1'b0;
    logic [7:0] last = 8'h00;
    wire logic rd = !fl_ce_b && !fl_oe_b;
    // busy_n reads also stand for a protected program: toggles a while, data unchanged
    wire logic busy = !aborted && (k < busy_n || stuck);
    wire logic susp = stuck && !fail_on && erase;
    // suspended sector: poll 1, primary steady, sector bit still toggles
    wire logic [7:0] stat = susp ? {1'b1, 1'b0, 1'b0, 1'b0, 1'b1, k[0], 2'b00}
        : {erase ? 1'b0 : ~arr[7], k[0], fail_on, 1'b0, erase && k != 0, erase && k[0], 2'b00};
    // a released bus shows the inverse of the last byte, never a stale copy
    assign fl_dq_i = rd ? (busy ? stat : arr) : ~last;
    always @(posedge ref_clk) begin
        rd_q <= rd;
        if (rd) begin
            last <= fl_dq_i;
            rd_addr <= fl_addr;
        end
        if (rd_q && !rd) k <= k + 1;
        if (!fl_we_b && !fl_ce_b && fl_dq_oe) begin
            wr_byte <= fl_dq_o;
            aborted <= 1'b1;
        end
        if (arm) begin
            k <= 0;
            aborted <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** fwsp_poll_ctrl_tb_top.sv ***
// Purpose: self-checking bench of the toggle polling controller
// Assumes: flash model answers on the pins, APB master in tasks
// Notes: expected verdict comes from a replay of the polling algorithm
`timescale 1ns/1ns
`default_nettype none
`include "fwsp_params.svh"
module fwsp_poll_ctrl_tb_top;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic arm = 1'b0;
    logic ff = 1'b0;
    logic st = 1'b0;
    logic sec = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, irq, e, fl_ce_b, fl_oe_b, fl_we_b, fl_dq_oe;
    logic [18:0] fl_addr, rd_addr;
    logic [7:0] fl_dq_o, fl_dq_i, wr_byte;
    logic [7:0] arr = 8'h00;
    logic [7:0] rcmd = 8'h00;
    int bn = 0;
    int mismatches = 0;
    int checked = 0;
    int cyc = 0;

    fwsp_poll_ctrl dut (.ref_clk(ref_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .fl_addr(fl_addr), .fl_ce_b(fl_ce_b), .fl_oe_b(fl_oe_b), .fl_we_b(fl_we_b), .fl_dq_o(fl_dq_o),
        .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i));
    fwsp_flash_model u_flash (.ref_clk(ref_clk), .arm(arm), .busy_n(bn[15:0]), .fail_on(ff), .stuck(st),
        .erase(sec), .arr(arr), .wr_byte(wr_byte), .rd_addr(rd_addr), .fl_addr(fl_addr), .fl_ce_b(fl_ce_b),
        .fl_oe_b(fl_oe_b), .fl_we_b(fl_we_b), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i));

    always #50 ref_clk = ~ref_clk;

    task automatic summarize();
        if (mismatches == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // byte the flash gives at its k-th read
    function automatic logic [7:0] fbyte(int k);
        if (st && !ff && sec) return {1'b1, 1'b0, 1'b0, 1'b0, 1'b1, k[0], 2'b00};
        if (k < bn || st) return {sec ? 1'b0 : ~arr[7], k[0], ff, 1'b0, sec && k != 0, sec && k[0], 2'b00};
        return arr;
    endfunction

    function automatic int predict(int lim);
        int k, r, p;
        logic [7:0] a, b;
        k = 0;
        r = 0;
        p = sec ? 2 : 6;
        while (1) begin
            a = fbyte(k);
            b = fbyte(k + 1);
            k += 2;
            if (a[p] == b[p]) return 1;
            if (b[5]) begin
                a = fbyte(k);
                b = fbyte(k + 1);
                return (a[p] == b[p]) ? 1 : 2;
            end
            r++;
            if (lim != 0 && r >= lim) return 3;
        end
    endfunction

    task automatic run(input int b, input logic f, input logic s, input int lim, input logic [2:0] en);
        int res, n;
        logic [18:0] ad;
        bn <= b;
        ff <= f;
        st <= s;
        // a suspended sector only shows up on the sector toggle bit
        sec <= (s && !f) | 1'($urandom);
        // bit 5 of array data kept low so a finished read never looks failed
        arr <= 8'($urandom) & 8'hDF;
        rcmd <= 8'($urandom);
        arm <= 1'b1;
        ad = 19'($urandom);
        @(posedge ref_clk);
        arm <= 1'b0;
        apb(1'b1, `FWSP_OFF_ADDR, 32'(ad));
        apb(1'b1, `FWSP_OFF_LIMIT, lim);
        apb(1'b1, `FWSP_OFF_RST_CMD, 32'(rcmd));
        apb(1'b1, `FWSP_OFF_IRQ_EN, 32'(en));
        res = predict(lim);
        apb(1'b1, `FWSP_OFF_CTRL, {30'h0, sec, 1'b1});
        n = 0;
        do begin
            apb(1'b0, `FWSP_OFF_STATUS, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 500);
        chk(32'(q[2:1]), res);
        chk(32'(rd_addr), 32'(ad));
        if (res == 1) begin
            apb(1'b0, `FWSP_OFF_DATA, 32'h0);
            chk(q, 32'(arr));
        end
        if (res == 2) chk(32'(wr_byte), 32'(rcmd));
        apb(1'b0, `FWSP_OFF_IRQ_STAT, 32'h0);
        chk(q, 32'(1) << (res - 1));
        chk(32'(irq), 32'(en[res-1]));
        apb(1'b1, `FWSP_OFF_IRQ_CLR, 32'h7);
        apb(1'b0, `FWSP_OFF_IRQ_STAT, 32'h0);
        chk(q, 32'h0);
        chk(32'(irq), 32'h0);
    endtask

    initial begin
        void'($urandom(1651));
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        apb(1'b0, `FWSP_OFF_LIMIT, 32'h0);
        chk(q, 32'(`FWSP_RST_LIMIT));
        apb(1'b0, `FWSP_OFF_RST_CMD, 32'h0);
        chk(q, 32'(`FWSP_RST_RST_CMD));
        apb(1'b0, `FWSP_OFF_IRQ_EN, 32'h0);
        chk(q, 32'(`FWSP_RST_IRQ_EN));
        apb(1'b0, 8'h24, 32'h0);
        chk(q, 32'h0);
        chk(32'(e), 32'h1);
        run(2 + $urandom % 8, 1'b0, 1'b0, 0, 3'h7);
        run(2, 1'b1, 1'b0, 0, 3'h7);
        run(2, 1'b1, 1'b1, 0, 3'h7);
        run(1000, 1'b0, 1'b0, 3, 3'h7);
        run(2, 1'b0, 1'b1, 3, 3'h5);
        run($urandom % 6, 1'b0, 1'b0, 0, 3'h0);
        summarize();
    end
endmodule
`default_nettype wire
